// ==== verilog/sdt_consts.vh ====
// Offsets, field positions, reset values and command codes of the timing bank
// Assumes a byte-addressed AXI4-Lite window whose low eight bits select a register
`ifndef SDT_CONSTS_VH
`define SDT_CONSTS_VH
`define SDT_OFS_RDLAT 8'h14
`define SDT_OFS_WSD 8'h18
`define SDT_OFS_MLT 8'h1c
`define SDT_OFS_RAS 8'h20
`define SDT_OFS_RC 8'h24
`define SDT_OFS_RCD 8'h28
`define SDT_OFS_RFC 8'h2c
`define SDT_OFS_RP 8'h30
`define SDT_OFS_RRD 8'h34
`define SDT_OFS_WR 8'h38
`define SDT_OFS_STAT 8'h60
`define SDT_RST_RDLAT 4'h6
`define SDT_RST_WSD 2'h1
`define SDT_RST_MLT 7'h02
`define SDT_RST_RAS 4'h7
`define SDT_RST_RC 4'hb
`define SDT_RST_RCD 6'h1d
`define SDT_RST_RFC 10'h212
`define SDT_RST_RP 6'h1d
`define SDT_RST_RRD 4'h2
`define SDT_RST_WR 3'h3
`define SDT_LAT_WHOLE_HI 3
`define SDT_LAT_WHOLE_LO 1
`define SDT_LAT_HALF 0
`define SDT_SCHED_LO 3
`define SDT_RFC_SCHED_LO 5
`define SDT_SCHED_BIAS 3'h3
`define SDT_MEM_SDR 3'h0
`define SDT_MEM_MOBILE 3'h3
`define SDT_CMD_MODE 3'h0
`define SDT_CMD_ACT 3'h1
`define SDT_CMD_RD 3'h2
`define SDT_CMD_WR 3'h3
`define SDT_CMD_PRE 3'h4
`define SDT_CMD_REF 3'h5
`define SDT_RESP_OK 2'h0
`define SDT_RESP_SLVERR 2'h2
`define SDT_RESP_DECERR 2'h3
`endif

// ==== verilog/sdt_spacing_timer.v ====
// Down-counter that measures one minimum command spacing
// Assumes load is a one-cycle pulse at the issuing edge
module sdt_spacing_timer #(
  parameter W = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire load,
  input wire [W-1:0] value,
  output wire done
);
  reg [W-1:0] cnt;

  // Spacing N lets the next command go N cycles later
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= {W{1'b0}};
    end else if (load) begin
      cnt <= (value == {W{1'b0}}) ? {W{1'b0}} : value - {{(W-1){1'b0}}, 1'b1};
    end else if (cnt != {W{1'b0}}) begin
      cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign done = (cnt == {W{1'b0}});
endmodule

// ==== verilog/sdt_bank_timers.v ====
// Per-bank spacing timers for one SDRAM bank
// Assumes the issue strobes are already qualified by bank select
module sdt_bank_timers (
  input wire aclk,
  input wire aresetn,
  input wire act,
  input wire pre,
  input wire wr,
  input wire [3:0] ras_val,
  input wire [3:0] rc_val,
  input wire [3:0] rcd_val,
  input wire [3:0] rp_val,
  input wire [2:0] wr_val,
  output wire act_ok,
  output wire pre_ok,
  output wire col_ok
);
  wire ras_done;
  wire rc_done;
  wire rcd_done;
  wire rp_done;
  wire wr_done;

  sdt_spacing_timer #(.W(4)) u_ras (.aclk(aclk), .aresetn(aresetn), .load(act), .value(ras_val), .done(ras_done));
  sdt_spacing_timer #(.W(4)) u_rc (.aclk(aclk), .aresetn(aresetn), .load(act), .value(rc_val), .done(rc_done));
  sdt_spacing_timer #(.W(4)) u_rcd (.aclk(aclk), .aresetn(aresetn), .load(act), .value(rcd_val), .done(rcd_done));
  sdt_spacing_timer #(.W(4)) u_rp (.aclk(aclk), .aresetn(aresetn), .load(pre), .value(rp_val), .done(rp_done));
  sdt_spacing_timer #(.W(3)) u_wr (.aclk(aclk), .aresetn(aresetn), .load(wr), .value(wr_val), .done(wr_done));

  assign act_ok = rc_done & rp_done;
  assign pre_ok = ras_done & wr_done;
  assign col_ok = rcd_done;
endmodule

// ==== verilog/sdt_timing_bank.v ====
// SDRAM timing parameter registers with command spacing gate
// Assumes an AXI4-Lite master and a command scheduler on the same aclk
`include "sdt_consts.vh"

module sdt_timing_bank #(
  parameter NB = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire ctrl_in_config,
  input wire ctrl_in_low_power,
  input wire [2:0] memory_type,
  input wire cmd_valid,
  input wire [2:0] cmd_kind,
  input wire [1:0] cmd_bank,
  output wire cmd_ready,
  output reg [2:0] read_latency_whole,
  output reg read_latency_half,
  output reg [1:0] write_strobe_delay
);
  reg [3:0] read_latency_reg;
  reg [1:0] write_strobe_delay_reg;
  reg [6:0] mode_load_time_reg;
  reg [3:0] row_active_min_reg;
  reg [3:0] row_cycle_time_reg;
  reg [5:0] row_to_column_delay_reg;
  reg [9:0] refresh_cmd_time_reg;
  reg [5:0] precharge_time_reg;
  reg [3:0] bank_to_bank_delay_reg;
  reg [2:0] write_recovery_time_reg;

  reg aw_hold;
  reg w_hold;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire access_open;
  wire wr_go;
  wire ar_go;
  wire [31:0] wr_merged;
  wire [31:0] stat_view;
  wire mobile_or_sdr;
  wire glob_ok;
  wire [NB-1:0] bank_act_ok;
  wire [NB-1:0] bank_pre_ok;
  wire [NB-1:0] bank_col_ok;
  wire mode_done;
  wire rfc_done;
  wire rrd_done;
  wire issue;
  reg kind_ok;
  reg [3:0] rcd_eff;
  reg [5:0] rfc_eff;
  reg [3:0] rp_eff;

  // Register decode, shared by read and write paths
  function is_timing;
    input [7:0] a;
    begin
      case (a)
        `SDT_OFS_RDLAT, `SDT_OFS_WSD, `SDT_OFS_MLT, `SDT_OFS_RAS, `SDT_OFS_RC,
        `SDT_OFS_RCD, `SDT_OFS_RFC, `SDT_OFS_RP, `SDT_OFS_RRD, `SDT_OFS_WR: is_timing = 1'b1;
        default: is_timing = 1'b0;
      endcase
    end
  endfunction

  // Zero-extended view of a timing register
  function [31:0] reg_view;
    input [7:0] a;
    begin
      case (a)
        `SDT_OFS_RDLAT: reg_view = {28'h0000000, read_latency_reg};
        `SDT_OFS_WSD: reg_view = {30'h00000000, write_strobe_delay_reg};
        `SDT_OFS_MLT: reg_view = {25'h0000000, mode_load_time_reg};
        `SDT_OFS_RAS: reg_view = {28'h0000000, row_active_min_reg};
        `SDT_OFS_RC: reg_view = {28'h0000000, row_cycle_time_reg};
        `SDT_OFS_RCD: reg_view = {26'h0000000, row_to_column_delay_reg};
        `SDT_OFS_RFC: reg_view = {22'h000000, refresh_cmd_time_reg};
        `SDT_OFS_RP: reg_view = {26'h0000000, precharge_time_reg};
        `SDT_OFS_RRD: reg_view = {28'h0000000, bank_to_bank_delay_reg};
        `SDT_OFS_WR: reg_view = {29'h00000000, write_recovery_time_reg};
        default: reg_view = 32'h00000000;
      endcase
    end
  endfunction

  // Byte-lane merge of write data into old contents
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0] s;
    integer i;
    begin
      lane_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (s[i]) begin
          lane_merge[i*8 +: 8] = d[i*8 +: 8];
        end
      end
    end
  endfunction

  assign access_open = ctrl_in_config | ctrl_in_low_power;

  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_hold && w_hold && !s_axi_bvalid;
  assign ar_go = s_axi_arvalid && !s_axi_rvalid;
  assign wr_merged = lane_merge(reg_view(aw_addr), w_data, w_strb);

  // Address and data may arrive in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end else if (wr_go) begin
        aw_hold <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SDT_RESP_OK;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      if (!is_timing(aw_addr) && aw_addr != `SDT_OFS_STAT) begin
        s_axi_bresp <= `SDT_RESP_DECERR;
      end else if (!access_open || aw_addr == `SDT_OFS_STAT) begin
        s_axi_bresp <= `SDT_RESP_SLVERR;
      end else begin
        s_axi_bresp <= `SDT_RESP_OK;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      read_latency_reg <= `SDT_RST_RDLAT;
      write_strobe_delay_reg <= `SDT_RST_WSD;
      mode_load_time_reg <= `SDT_RST_MLT;
      row_active_min_reg <= `SDT_RST_RAS;
      row_cycle_time_reg <= `SDT_RST_RC;
      row_to_column_delay_reg <= `SDT_RST_RCD;
      refresh_cmd_time_reg <= `SDT_RST_RFC;
      precharge_time_reg <= `SDT_RST_RP;
      bank_to_bank_delay_reg <= `SDT_RST_RRD;
      write_recovery_time_reg <= `SDT_RST_WR;
    end else if (wr_go && access_open) begin
      case (aw_addr)
        `SDT_OFS_RDLAT: read_latency_reg <= wr_merged[3:0];
        `SDT_OFS_WSD: write_strobe_delay_reg <= wr_merged[1:0];
        `SDT_OFS_MLT: mode_load_time_reg <= wr_merged[6:0];
        `SDT_OFS_RAS: row_active_min_reg <= wr_merged[3:0];
        `SDT_OFS_RC: row_cycle_time_reg <= wr_merged[3:0];
        `SDT_OFS_RCD: row_to_column_delay_reg <= wr_merged[5:0];
        `SDT_OFS_RFC: refresh_cmd_time_reg <= wr_merged[9:0];
        `SDT_OFS_RP: precharge_time_reg <= wr_merged[5:0];
        `SDT_OFS_RRD: bank_to_bank_delay_reg <= wr_merged[3:0];
        `SDT_OFS_WR: write_recovery_time_reg <= wr_merged[2:0];
        default: read_latency_reg <= read_latency_reg;
      endcase
    end
  end

  assign stat_view = {22'h000000, {(8-NB){1'b0}}, bank_act_ok, access_open, glob_ok};

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SDT_RESP_OK;
    end else if (ar_go) begin
      s_axi_rvalid <= 1'b1;
      if ({s_axi_araddr[7:2], 2'b00} == `SDT_OFS_STAT) begin
        s_axi_rdata <= stat_view;
        s_axi_rresp <= `SDT_RESP_OK;
      end else if (!is_timing({s_axi_araddr[7:2], 2'b00})) begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `SDT_RESP_DECERR;
      end else if (!access_open) begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `SDT_RESP_SLVERR;
      end else begin
        s_axi_rdata <= reg_view({s_axi_araddr[7:2], 2'b00});
        s_axi_rresp <= `SDT_RESP_OK;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign mobile_or_sdr = (memory_type == `SDT_MEM_MOBILE) || (memory_type == `SDT_MEM_SDR);

  always @(posedge aclk) begin
    if (!aresetn) begin
      read_latency_whole <= 3'h0;
      read_latency_half <= 1'b0;
      write_strobe_delay <= 2'h0;
    end else begin
      read_latency_whole <= read_latency_reg[`SDT_LAT_WHOLE_HI:`SDT_LAT_WHOLE_LO];
      read_latency_half <= read_latency_reg[`SDT_LAT_HALF] & !mobile_or_sdr;
      write_strobe_delay <= write_strobe_delay_reg;
    end
  end

  // Spacing is the larger of memory count and schedule count
  always @* begin
    rcd_eff = {1'b0, row_to_column_delay_reg[2:0]};
    if ({1'b0, row_to_column_delay_reg[5:3]} + {1'b0, `SDT_SCHED_BIAS} > rcd_eff) begin
      rcd_eff = {1'b0, row_to_column_delay_reg[5:3]} + {1'b0, `SDT_SCHED_BIAS};
    end
    rfc_eff = {1'b0, refresh_cmd_time_reg[4:0]};
    if ({1'b0, refresh_cmd_time_reg[9:5]} + {3'b000, `SDT_SCHED_BIAS} > rfc_eff) begin
      rfc_eff = {1'b0, refresh_cmd_time_reg[9:5]} + {3'b000, `SDT_SCHED_BIAS};
    end
    rp_eff = {1'b0, precharge_time_reg[2:0]};
    if ({1'b0, precharge_time_reg[5:3]} + {1'b0, `SDT_SCHED_BIAS} > rp_eff) begin
      rp_eff = {1'b0, precharge_time_reg[5:3]} + {1'b0, `SDT_SCHED_BIAS};
    end
  end

  assign issue = cmd_valid & cmd_ready;

  sdt_spacing_timer #(.W(7)) u_mode (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(issue && cmd_kind == `SDT_CMD_MODE),
    .value(mode_load_time_reg),
    .done(mode_done)
  );

  sdt_spacing_timer #(.W(6)) u_rfc (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(issue && cmd_kind == `SDT_CMD_REF),
    .value(rfc_eff),
    .done(rfc_done)
  );

  sdt_spacing_timer #(.W(4)) u_rrd (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(issue && cmd_kind == `SDT_CMD_ACT),
    .value(bank_to_bank_delay_reg),
    .done(rrd_done)
  );

  genvar b;
  generate
    for (b = 0; b < NB; b = b + 1) begin : g_bank
      wire hit;
      assign hit = issue && ({30'b0, cmd_bank} == b);
      sdt_bank_timers u_bank (
        .aclk(aclk),
        .aresetn(aresetn),
        .act(hit && cmd_kind == `SDT_CMD_ACT),
        .pre(hit && cmd_kind == `SDT_CMD_PRE),
        .wr(hit && cmd_kind == `SDT_CMD_WR),
        .ras_val(row_active_min_reg),
        .rc_val(row_cycle_time_reg),
        .rcd_val(rcd_eff),
        .rp_val(rp_eff),
        .wr_val(write_recovery_time_reg),
        .act_ok(bank_act_ok[b]),
        .pre_ok(bank_pre_ok[b]),
        .col_ok(bank_col_ok[b])
      );
    end
  endgenerate

  assign glob_ok = mode_done & rfc_done;

  always @* begin
    case (cmd_kind)
      `SDT_CMD_ACT: kind_ok = bank_act_ok[cmd_bank] & rrd_done;
      `SDT_CMD_RD: kind_ok = bank_col_ok[cmd_bank];
      `SDT_CMD_WR: kind_ok = bank_col_ok[cmd_bank];
      `SDT_CMD_PRE: kind_ok = bank_pre_ok[cmd_bank];
      `SDT_CMD_REF: kind_ok = &bank_act_ok;
      `SDT_CMD_MODE: kind_ok = &bank_act_ok;
      default: kind_ok = 1'b1;
    endcase
  end

  assign cmd_ready = glob_ok & kind_ok;
endmodule

// ==== dv/sdt_timing_bank_assertions.sv ====
// Concurrent checks on the timing bank register port and latency outputs
// Assumes binding to sdt_timing_bank with one aclk domain
module sdt_timing_bank_chk (
  input logic aclk,
  input logic aresetn,
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic ctrl_in_config,
  input logic ctrl_in_low_power,
  input logic [2:0] memory_type,
  input logic [2:0] read_latency_whole,
  input logic read_latency_half
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire open_w = ctrl_in_config | ctrl_in_low_power;
  wire aw_t = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  wire ar_t = s_axi_arvalid & s_axi_arready;
  write_answer_a: assert property (aw_t |=> ##1 s_axi_bvalid) // write answered
    else $error("write not answered");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  read_answer_a: assert property (ar_t |=> s_axi_rvalid) // read answered
    else $error("read not answered");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) // single read
    else $error("read taken while answering");
  closed_read_a: assert property (ar_t && !open_w && s_axi_araddr >= 8'h14 && s_axi_araddr <= 8'h38
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) // closed window
    else $error("closed window read not refused");
  half_forced_a: assert property (memory_type == 3'h0 || memory_type == 3'h3 |=> !read_latency_half)
    else $error("half cycle not forced off");
  latency_copy_a: assert property (aw_t && open_w && s_axi_awaddr == 8'h14
    |=> ##2 read_latency_whole == $past(s_axi_wdata[3:1], 3)) // whole cycles
    else $error("latency output wrong");
endmodule

bind sdt_timing_bank sdt_timing_bank_chk sdt_timing_bank_chk_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .ctrl_in_config, .ctrl_in_low_power, .memory_type, .read_latency_whole, .read_latency_half);

// ==== dv/sdt_sched_model.sv ====
// Command source standing in for the scheduler facing the SDRAM
// Assumes cmd_ready is settled by the falling edge of aclk
module sdt_sched_model (
  input logic aclk,
  input logic cmd_ready,
  output logic cmd_valid,
  output logic [2:0] cmd_kind,
  output logic [1:0] cmd_bank
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc = 0;
  int last = 0;
  initial begin
    cmd_valid = 1'b0;
    cmd_kind = 3'h7;
    cmd_bank = 2'h0;
  end
  always @(posedge aclk) cyc <= cyc + 1;
  // Offer a command, return edges since the previous issue
  task automatic issue(input logic [2:0] k, input logic [1:0] b, output int gap);
    @(posedge aclk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_bank <= b;
    do @(negedge aclk); while (cmd_ready !== 1'b1);
    gap = cyc + 1 - last;
    last = cyc + 1;
    @(posedge aclk);
    cmd_valid <= 1'b0;
    cmd_kind <= 3'h7;
    cmd_bank <= ~b;
  endtask
endmodule

// ==== dv/test_sdt_timing_bank.sv ====
// Self-checking bench for the timing parameter bank
// Assumes the scheduler model drives the command gate inputs
module test_sdt_timing_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic cfg = 1'b1, lowp = 1'b0;
  logic [2:0] mtype = 3'h1;
  wire awready, wready, bvalid, arready, rvalid, cmd_valid, cmd_ready, half;
  wire [1:0] bresp, rresp, cmd_bank, wsd;
  wire [31:0] rdata;
  wire [2:0] cmd_kind, whole;
  int fails = 0;
  int total_checks = 0;
  logic [31:0] d;
  logic [1:0] r;
  int g;
  logic [7:0] ofs [10] = '{8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38};
  logic [31:0] rst [10] = '{32'h6, 32'h1, 32'h2, 32'h7, 32'hb, 32'h1d, 32'h212, 32'h1d, 32'h2, 32'h3};
  logic [31:0] msk [10] = '{32'hf, 32'h3, 32'h7f, 32'hf, 32'hf, 32'h3f, 32'h3ff, 32'h3f, 32'hf, 32'h7};
  // Spacing rows: register, value, {kind1, bank1, kind2, bank2}, expected gap
  logic [7:0] sofs [10] = '{8'h28, 8'h28, 8'h20, 8'h24, 8'h34, 8'h30, 8'h38, 8'h1c, 8'h2c, 8'h2c};
  logic [31:0] sval [10] = '{32'h6, 32'h21, 32'h5, 32'h9, 32'h4, 32'h22, 32'h6, 32'ha, 32'h2c, 32'hc2};
  logic [9:0] cmds [10] = '{10'h088, 10'h0ad, 10'h0b1, 10'h0c6, 10'h0e4, 10'h225, 10'h1d2, 10'h004, 10'h287, 10'h286};
  logic [31:0] gap [10] = '{32'h6, 32'h7, 32'h5, 32'h9, 32'h4, 32'h7, 32'h6, 32'ha, 32'hc, 32'h9};
  always #10 aclk = ~aclk;
  sdt_timing_bank sdt_timing_bank_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ctrl_in_config(cfg), .ctrl_in_low_power(lowp), .memory_type(mtype),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_bank(cmd_bank), .cmd_ready(cmd_ready),
    .read_latency_whole(whole), .read_latency_half(half), .write_strobe_delay(wsd));
  sdt_sched_model sdt_sched_model_i (.aclk(aclk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_bank(cmd_bank));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw = aw & !awready;
      w = w & !wready;
      @(posedge aclk);
      awvalid <= aw;
      wvalid <= w;
    end while (aw | w);
    do @(negedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic give_verdict;
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(negedge aclk);
    chk({28'h0, whole, half}, 32'h6); // latency reset
    chk({30'h0, wsd}, 32'h1); // strobe reset
    for (int i = 0; i < 10; i++) begin
      axr(ofs[i], d, r);
      chk(d, rst[i]); // reset values
      axw(ofs[i], 32'hffffffff, r);
      chk({30'h0, r}, 32'h0); // open write accepted
      axr(ofs[i], d, r);
      chk(d, msk[i]); // reserved bits zero
      axw(ofs[i], rst[i], r);
    end
    for (int i = 0; i < 10; i++) begin
      axw(sofs[i], sval[i], r);
      repeat (24) @(posedge aclk);
      sdt_sched_model_i.issue(cmds[i][9:7], cmds[i][6:5], g);
      sdt_sched_model_i.issue(cmds[i][4:2], cmds[i][1:0], g);
      chk(g, gap[i]); // spacing
    end
    axw(8'h14, 32'hb, r);
    axw(8'h18, 32'h2, r);
    for (int t = 0; t < 4; t++) begin
      @(posedge aclk);
      mtype <= t[2:0];
      repeat (3) @(negedge aclk);
      chk({29'h0, whole}, 32'h5); // whole cycles
      chk({31'h0, half}, {31'h0, t == 1 || t == 2}); // half forced
    end
    chk({30'h0, wsd}, 32'h2); // strobe delay
    @(posedge aclk);
    cfg <= 1'b0;
    axw(8'h20, 32'h3, r);
    chk({30'h0, r}, 32'h2); // closed write refused
    axr(8'h20, d, r);
    chk(d, 32'h0); // closed read empty
    chk({30'h0, r}, 32'h2); // closed read refused
    @(posedge aclk);
    lowp <= 1'b1;
    axr(8'h20, d, r);
    chk(d, 32'h5); // low-power open
    chk({30'h0, r}, 32'h0); // low-power open
    axr(8'h00, d, r);
    chk({30'h0, r}, 32'h3); // unmapped read
    axw(8'h04, 32'h1, r);
    chk({30'h0, r}, 32'h3); // unmapped write
    axw(8'h60, 32'h1, r);
    chk({30'h0, r}, 32'h2); // status write refused
    axr(8'h60, d, r);
    chk(d, 32'h3f); // activate and global spacings elapsed
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(negedge aclk);
    chk({28'h0, whole, half}, 32'h6); // latency after second reset
    chk({30'h0, wsd}, 32'h1); // strobe after second reset
    axr(8'h14, d, r);
    chk(d, 32'h6); // register after second reset
    give_verdict;
  end
endmodule
